// file: flash_isp_pkg.sv
// Shared constants and types of the in-system flash programming sequencer.
// Assumes a 32-bit APB slave port and a byte-wide flash array outside the block.
`default_nettype none

package flash_isp_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CHIP_CONTROL       = 8'h9f;
	localparam logic [7:0] IDX_FLASH_TRIGGER      = 8'ha4;
	localparam logic [7:0] IDX_FLASH_COMMAND      = 8'ha5;
	localparam logic [7:0] IDX_FLASH_ADDRESS_LOW  = 8'ha6;
	localparam logic [7:0] IDX_FLASH_ADDRESS_HIGH = 8'ha7;
	localparam logic [7:0] IDX_FLASH_DATA         = 8'hae;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CC_FAULT_BIT   = 6;
	localparam int CC_LOADER_UPDATE_ENABLE_BIT   = 5;
	localparam int CC_ENABLE_BIT  = 0;
	localparam int TRIG_GO_BIT    = 0;
	localparam int CMD_AREA_MSB   = 7;
	localparam int CMD_AREA_LSB   = 6;
	localparam int CMD_OE_BIT     = 5;
	localparam int CMD_CE_BIT     = 4;
	localparam int CMD_FUNC_MSB   = 3;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Function codes and target areas
	localparam logic [3:0] FUNC_ERASE   = 4'h2;
	localparam logic [3:0] FUNC_PROGRAM = 4'h1;
	localparam logic [3:0] FUNC_READ    = 4'h0;
	localparam logic [1:0] AREA_APP     = 2'h0;
	localparam logic [1:0] AREA_LOADER  = 2'h1;
	localparam logic [1:0] AREA_CONFIG  = 2'h3;
	localparam int CONFIG_BYTES = 4;

	// ----------------------------------------------------------------
	// Timing (least times, rounded up to whole clock cycles)
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int ERASE_TIME_NS   = 5000000;
	localparam int PROGRAM_TIME_NS = 30000;
	localparam int READ_TIME_NS    = 200;
	localparam int ERASE_CYCLES    = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROGRAM_CYCLES  = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYCLES     = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 20;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b11
	} seq_state_t;

	typedef enum logic [1:0] {
		OP_NONE    = 2'h0,
		OP_ERASE   = 2'h1,
		OP_PROGRAM = 2'h2,
		OP_READ    = 2'h3
	} flash_op_t;

	typedef struct packed {
		flash_op_t   op;
		logic [17:0] addr;
		logic [7:0]  wdata;
	} flash_req_t;

endpackage : flash_isp_pkg

`default_nettype wire

// file: in_system_flash_programming.sv
// In-system flash programming sequencer: APB register file, legality check,
// CPU hold and erase/program/read timing toward an external flash array.
// Assumes the timed-access unlock, the array and its pump driver live outside.
//
// Notes on behaviour
// - Flash operations are possible only while the programming enable bit is set.
// - The programming enable bit also runs the internal RC oscillator.
// - Command register: address 17:16, output enable, chip enable, function code.
// - Writing one to the trigger bit starts the selected operation.
// - The CPU is held and hardware drives pump and timing while busy.
// - On completion the trigger bit clears and the CPU is released.
// - The trigger bit is write-only and reads back as zero.
// - Trigger and chip control writes act only when the unlock is open.
// - Data register feeds programming and captures read or verify data.
// - Fault when application code erases or programs the application area below the data flash base.
// - Fault when application code writes loader area with loader update off.
// - Fault when application code touches any option configuration byte.
// - Fault when loader code erases or programs the loader area.
// - Fault on oversize access or execution running into external memory.
// - Hardware only sets the fault flag; software clears it by writing.
// - Loader update enable decides whether application code may write loader area.
// - Codes 0010 erase, 0001 program, 0000 read with matching enable bits.
// - Page erase clears the 256-byte page chosen by the high address byte.
`timescale 1ns/1ps
`default_nettype none

module in_system_flash_programming #(
	parameter int ERASE_CYCLES    = flash_isp_pkg::ERASE_CYCLES,
	parameter int PROGRAM_CYCLES  = flash_isp_pkg::PROGRAM_CYCLES,
	parameter int READ_CYCLES     = flash_isp_pkg::READ_CYCLES,
	parameter int APP_BYTES       = 32768,
	parameter int DATA_FLASH_BASE = 28672,
	parameter int LOADER_BYTES    = 4096
) (
	input  wire logic                      mclk,
	input  wire logic                      rstn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output var  logic [31:0]               prdata,
	output var  logic                      pready,
	output var  logic                      pslverr,
	input  wire logic                      timedAccessOpen,
	input  wire logic                      codeInLoader,
	input  wire logic                      fetchExternal,
	input  wire logic [7:0]                flashRdData,
	output var  flash_isp_pkg::flash_req_t flashReq,
	output var  logic                      flashStrobe,
	output var  logic                      pumpEnable,
	output var  logic                      rcOscEnable,
	output var  logic                      cpuHold
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Command byte to operation; unknown or standby codes give no operation
	function automatic flash_isp_pkg::flash_op_t decodeOp(input logic [7:0] cmd);
		logic       oe;
		logic       ce;
		logic [3:0] fn;
		oe = cmd[flash_isp_pkg::CMD_OE_BIT];
		ce = cmd[flash_isp_pkg::CMD_CE_BIT];
		fn = cmd[flash_isp_pkg::CMD_FUNC_MSB:0];
		if (oe && !ce && fn == flash_isp_pkg::FUNC_ERASE) begin
			decodeOp = flash_isp_pkg::OP_ERASE;
		end else if (oe && !ce && fn == flash_isp_pkg::FUNC_PROGRAM) begin
			decodeOp = flash_isp_pkg::OP_PROGRAM;
		end else if (!oe && !ce && fn == flash_isp_pkg::FUNC_READ) begin
			decodeOp = flash_isp_pkg::OP_READ;
		end else begin
			decodeOp = flash_isp_pkg::OP_NONE;
		end
	endfunction : decodeOp

	// Operation writes the array (erase or program)
	function automatic logic isWriteOp(input flash_isp_pkg::flash_op_t op);
		isWriteOp = (op == flash_isp_pkg::OP_ERASE) || (op == flash_isp_pkg::OP_PROGRAM);
	endfunction : isWriteOp

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic                       faultReg;
	logic                       faultNext;
	logic                       loaderUpdateEnableReg;
	logic                       programmingEnableReg;
	logic [7:0]                 commandReg;
	logic [7:0]                 addressHighReg;
	logic [7:0]                 addressLowReg;
	logic [7:0]                 dataReg;
	logic                       goReg;
	flash_isp_pkg::seq_state_t  stateReg;
	flash_isp_pkg::seq_state_t  stateNext;
	logic [flash_isp_pkg::CNT_W-1:0] cntReg;
	logic [31:0]                prdataReg;
	logic                       preadyReg;
	logic                       pslverrReg;
	flash_isp_pkg::flash_req_t  reqReg;
	logic                       strobeReg;
	logic                       pumpReg;
	logic                       holdReg;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire logic       accessPhase = psel && penable;
	wire logic       busDone     = accessPhase && preadyReg;
	wire logic [7:0] regIndex    = paddr[9:2];
	wire logic       addrHigh0   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
	wire logic       hitChip     = addrHigh0 && regIndex == flash_isp_pkg::IDX_CHIP_CONTROL;
	wire logic       hitTrig     = addrHigh0 && regIndex == flash_isp_pkg::IDX_FLASH_TRIGGER;
	wire logic       hitCmd      = addrHigh0 && regIndex == flash_isp_pkg::IDX_FLASH_COMMAND;
	wire logic       hitAddrLo   = addrHigh0 && regIndex == flash_isp_pkg::IDX_FLASH_ADDRESS_LOW;
	wire logic       hitAddrHi   = addrHigh0 && regIndex == flash_isp_pkg::IDX_FLASH_ADDRESS_HIGH;
	wire logic       hitData     = addrHigh0 && regIndex == flash_isp_pkg::IDX_FLASH_DATA;
	wire logic       hitAny      = hitChip || hitTrig || hitCmd || hitAddrLo || hitAddrHi
	                               || hitData;
	wire logic       wrStrobe    = busDone && pwrite && hitAny;

	// Protected writes need the unlock window open at the completing edge
	wire logic chipWrite = wrStrobe && hitChip && timedAccessOpen;
	wire logic trigWrite = wrStrobe && hitTrig && timedAccessOpen;

	// Read multiplexer; trigger bit never reads back
	logic [7:0] readByte;
	always_comb begin
		readByte = 8'h00;
		if (hitChip) begin
			readByte[flash_isp_pkg::CC_FAULT_BIT]  = faultReg;
			readByte[flash_isp_pkg::CC_LOADER_UPDATE_ENABLE_BIT]  = loaderUpdateEnableReg;
			readByte[flash_isp_pkg::CC_ENABLE_BIT] = programmingEnableReg;
		end else if (hitCmd) begin
			readByte = commandReg;
		end else if (hitAddrLo) begin
			readByte = addressLowReg;
		end else if (hitAddrHi) begin
			readByte = addressHighReg;
		end else if (hitData) begin
			readByte = dataReg;
		end else begin
			readByte = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Command decode and legality check
	// ----------------------------------------------------------------
	wire flash_isp_pkg::flash_op_t reqOp = decodeOp(commandReg);
	wire logic [1:0]  reqArea  = commandReg[flash_isp_pkg::CMD_AREA_MSB:flash_isp_pkg::CMD_AREA_LSB];
	wire logic [15:0] reqAddr  = {addressHighReg, addressLowReg};
	wire logic        reqWrite = isWriteOp(reqOp);
	wire logic        inApp    = reqArea == flash_isp_pkg::AREA_APP;
	wire logic        inLoader = reqArea == flash_isp_pkg::AREA_LOADER;
	wire logic        inConfig = reqArea == flash_isp_pkg::AREA_CONFIG;
	wire logic        appCode  = !codeInLoader;

	// Data flash shares the application address space above its base
	wire logic inDataFlash = inApp && (32'(reqAddr) >= DATA_FLASH_BASE);

	// Oversize: beyond the implemented area, or the unused area code
	wire logic oversize = (inApp && (32'(reqAddr) >= APP_BYTES))
	                      || (inLoader && (32'(reqAddr) >= LOADER_BYTES))
	                      || (inConfig && (reqOp == flash_isp_pkg::OP_ERASE)
	                          && addressHighReg != 8'h00)
	                      || (inConfig && (reqOp != flash_isp_pkg::OP_ERASE)
	                          && (32'(reqAddr) >= flash_isp_pkg::CONFIG_BYTES))
	                      || (reqArea == 2'h2);

	wire logic faultAppSelf   = appCode && reqWrite && inApp && !inDataFlash;
	wire logic faultLdrLocked = appCode && reqWrite && inLoader
	                            && !loaderUpdateEnableReg;
	wire logic faultConfig    = appCode && inConfig
	                            && reqOp != flash_isp_pkg::OP_NONE;
	wire logic faultLdrSelf   = codeInLoader && reqWrite && inLoader;
	wire logic faultSize      = (oversize && reqOp != flash_isp_pkg::OP_NONE)
	                            || fetchExternal;
	wire logic illegal        = faultAppSelf || faultLdrLocked || faultConfig
	                            || faultLdrSelf || faultSize;

	// Trigger is taken only when enabled and the sequencer is idle
	wire logic startOp = trigWrite && pwdata[flash_isp_pkg::TRIG_GO_BIT]
	                     && programmingEnableReg
	                     && stateReg == flash_isp_pkg::ST_IDLE;
	wire logic startRun   = startOp && !illegal && reqOp != flash_isp_pkg::OP_NONE;
	wire logic setFault   = startOp && illegal;

	// Erase targets a whole page, so the low address byte is dropped
	wire logic [15:0] pageAddr = (reqOp == flash_isp_pkg::OP_ERASE)
	                             ? {addressHighReg, 8'h00} : reqAddr;

	// Operation length in cycles
	wire logic [flash_isp_pkg::CNT_W-1:0] opCycles =
		(reqOp == flash_isp_pkg::OP_ERASE)   ? flash_isp_pkg::CNT_W'(ERASE_CYCLES) :
		(reqOp == flash_isp_pkg::OP_PROGRAM) ? flash_isp_pkg::CNT_W'(PROGRAM_CYCLES) :
		                                       flash_isp_pkg::CNT_W'(READ_CYCLES);

	wire logic runLast = stateReg == flash_isp_pkg::ST_RUN
	                     && cntReg == flash_isp_pkg::CNT_W'(1);

	// Fault flag: a hardware set in the same cycle as a clear wins
	assign faultNext = setFault ? 1'b1
	                 : chipWrite ? pwdata[flash_isp_pkg::CC_FAULT_BIT]
	                 : faultReg;

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		case (stateReg)
			flash_isp_pkg::ST_IDLE: begin
				if (startRun) begin
					stateNext = flash_isp_pkg::ST_RUN;
				end else if (startOp) begin
					stateNext = flash_isp_pkg::ST_DONE;
				end else begin
					stateNext = flash_isp_pkg::ST_IDLE;
				end
			end
			flash_isp_pkg::ST_RUN: begin
				stateNext = runLast ? flash_isp_pkg::ST_DONE : flash_isp_pkg::ST_RUN;
			end
			flash_isp_pkg::ST_DONE: begin
				stateNext = flash_isp_pkg::ST_IDLE;
			end
			default: begin
				stateNext = flash_isp_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// APB answer: one wait state, registered data and error
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			preadyReg  <= 1'b0;
			pslverrReg <= 1'b0;
			prdataReg  <= 32'h0000_0000;
		end else begin
			preadyReg  <= accessPhase && !preadyReg;
			pslverrReg <= accessPhase && !preadyReg && !hitAny;
			prdataReg  <= (accessPhase && !preadyReg && !pwrite) ? {24'h00_0000, readByte}
			                                                     : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------

	// Chip control is protected; other bits of that byte are not ours
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			faultReg              <= 1'b0;
			loaderUpdateEnableReg <= 1'b0;
			programmingEnableReg  <= 1'b0;
		end else begin
			faultReg <= faultNext;
			if (chipWrite) begin
				loaderUpdateEnableReg <= pwdata[flash_isp_pkg::CC_LOADER_UPDATE_ENABLE_BIT];
				programmingEnableReg  <= pwdata[flash_isp_pkg::CC_ENABLE_BIT];
			end
		end
	end

	// Command and address bytes, loaded by software before a trigger
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			commandReg     <= flash_isp_pkg::RESET_BYTE;
			addressHighReg <= flash_isp_pkg::RESET_BYTE;
			addressLowReg  <= flash_isp_pkg::RESET_BYTE;
		end else begin
			if (wrStrobe && hitCmd) begin
				commandReg <= pwdata[7:0];
			end
			if (wrStrobe && hitAddrHi) begin
				addressHighReg <= pwdata[7:0];
			end
			if (wrStrobe && hitAddrLo) begin
				addressLowReg <= pwdata[7:0];
			end
		end
	end

	// Data byte: software value, replaced by the array byte after a read
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dataReg <= flash_isp_pkg::RESET_BYTE;
		end else if (runLast && reqReg.op == flash_isp_pkg::OP_READ) begin
			dataReg <= flashRdData;
		end else if (wrStrobe && hitData) begin
			dataReg <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Sequencer, counter and flash drive
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stateReg <= flash_isp_pkg::ST_IDLE;
			cntReg   <= '0;
			goReg    <= 1'b0;
		end else begin
			stateReg <= stateNext;
			if (startRun) begin
				cntReg <= opCycles;
			end else if (stateReg == flash_isp_pkg::ST_RUN) begin
				cntReg <= cntReg - flash_isp_pkg::CNT_W'(1);
			end
			if (startOp) begin
				goReg <= 1'b1;
			end else if (stateReg == flash_isp_pkg::ST_DONE) begin
				goReg <= 1'b0;
			end
		end
	end

	// Array request latched at the start; the array only acts on a strobe,
	// so a refused operation never reaches it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reqReg      <= '0;
			strobeReg   <= 1'b0;
			pumpReg     <= 1'b0;
			holdReg     <= 1'b0;
		end else begin
			if (startRun) begin
				reqReg.op    <= reqOp;
				reqReg.addr  <= {reqArea, pageAddr};
				reqReg.wdata <= dataReg;
			end
			strobeReg <= startRun || (stateReg == flash_isp_pkg::ST_RUN && !runLast);
			pumpReg   <= (startRun && reqWrite)
			             || (pumpReg && !runLast);
			holdReg   <= startOp || (holdReg && stateReg != flash_isp_pkg::ST_DONE);
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign prdata      = prdataReg;
	assign pready      = preadyReg;
	assign pslverr     = pslverrReg;
	assign flashReq    = reqReg;
	assign flashStrobe = strobeReg;
	assign pumpEnable  = pumpReg;
	assign rcOscEnable = programmingEnableReg;
	assign cpuHold     = holdReg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_TRIGGER_READS_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
		busDone && !pwrite && hitTrig |-> prdata == 32'h0000_0000)
		else $error("trigger register read back non-zero");

	AST_HOLD_ON_START: assert property (@(posedge mclk) disable iff (!rstn)
		startRun |=> cpuHold && flashStrobe [*2])
		else $error("cpu not held while operation runs");

	AST_RELEASE_AFTER_DONE: assert property (@(posedge mclk) disable iff (!rstn)
		stateReg == flash_isp_pkg::ST_DONE |=> !cpuHold && !goReg)
		else $error("cpu or trigger not released after completion");

	AST_ILLEGAL_NO_FLASH: assert property (@(posedge mclk) disable iff (!rstn)
		setFault |=> faultReg && cpuHold && !flashStrobe ##1 !cpuHold && !flashStrobe)
		else $error("illegal operation reached the array or hung");

	AST_LOCKED_CHIP_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
		wrStrobe && hitChip && !timedAccessOpen |=> $stable(programmingEnableReg))
		else $error("chip control changed without unlock");

	AST_DISABLED_NO_START: assert property (@(posedge mclk) disable iff (!rstn)
		trigWrite && !programmingEnableReg && !cpuHold |=> !cpuHold)
		else $error("operation started while disabled");

	AST_ERASE_PAGE_ALIGN: assert property (@(posedge mclk) disable iff (!rstn)
		flashStrobe && flashReq.op == flash_isp_pkg::OP_ERASE |-> flashReq.addr[7:0] == 8'h00)
		else $error("erase address not page aligned");

	AST_FAULT_STICKY: assert property (@(posedge mclk) disable iff (!rstn)
		faultReg && !chipWrite |=> faultReg)
		else $error("fault flag cleared by hardware");

	AST_READ_CAPTURE: assert property (@(posedge mclk) disable iff (!rstn)
		runLast && reqReg.op == flash_isp_pkg::OP_READ |=> dataReg == $past(flashRdData))
		else $error("read byte not captured");

	AST_PUMP_WRITE_ONLY: assert property (@(posedge mclk) disable iff (!rstn)
		pumpEnable |-> cpuHold && isWriteOp(flashReq.op))
		else $error("pump on outside erase or program");

endmodule : in_system_flash_programming

`default_nettype wire

// file: in_system_flash_programming_bench.sv
// Self-checking bench for the in-system flash programming sequencer.
// Assumes flash_isp_pkg is compiled first; the bench plays APB master and CPU status.
`timescale 1ns/1ps
`default_nettype none

module in_system_flash_programming_bench;
	logic                      mclk, rstn, psel, penable, pwrite, pready, pslverr;
	logic                      ta, inLoader, extFetch, strobe, pump, osc, hold, err;
	logic [11:0]               paddr;
	logic [31:0]               pwdata, prdata, rd;
	logic [7:0]                flashRd, ccVal;
	flash_isp_pkg::flash_req_t req, seenReq;
	int                        mismatches, totalChecks, cycles;

	// Short counts keep each erase and program window small
	in_system_flash_programming #(.ERASE_CYCLES(8), .PROGRAM_CYCLES(4), .READ_CYCLES(2))
		in_system_flash_programming_inst (.mclk(mclk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timedAccessOpen(ta), .codeInLoader(inLoader),
		.fetchExternal(extFetch), .flashRdData(flashRd), .flashReq(req), .flashStrobe(strobe),
		.pumpEnable(pump), .rcOscEnable(osc), .cpuHold(hold));

	// ----------------------------------------------------------------
	// Clock, hang guard and shared tasks
	// ----------------------------------------------------------------
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; waits an edge first so no signal is driven twice in a step
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		// Only the bench's hang guard ends a wait for the answer
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Loads and fires one operation, then judges strobe, hold, pump and fault
	task run_op(input logic [7:0] cmd, ah, d, input int n, input logic f, input logic [19:0] exp);
		int sc, hc, pc;
		sc = 0;
		hc = 0;
		pc = 0;
		apb(1'b1, flash_isp_pkg::IDX_FLASH_COMMAND, cmd);
		apb(1'b1, flash_isp_pkg::IDX_FLASH_ADDRESS_HIGH, ah);
		apb(1'b1, flash_isp_pkg::IDX_FLASH_ADDRESS_LOW, exp[7:0] | 8'h33);
		apb(1'b1, flash_isp_pkg::IDX_FLASH_DATA, d);
		apb(1'b1, flash_isp_pkg::IDX_FLASH_TRIGGER, 8'h01);
		repeat (14) begin
			@(posedge mclk);
			sc += int'(strobe);
			hc += int'(hold);
			pc += int'(pump);
			if (strobe === 1'b1) seenReq = req;
		end
		check(sc, n);
		check(hc, n + 1);
		check(pc, (exp[19:18] == 2'h3) ? 0 : n);
		if (n > 0) check({12'h000, seenReq.op, seenReq.addr}, {12'h000, exp});
		apb(1'b0, flash_isp_pkg::IDX_CHIP_CONTROL, 8'h00);
		check({31'h0, rd[6]}, {31'h0, f});
		apb(1'b0, flash_isp_pkg::IDX_FLASH_TRIGGER, 8'h00);
		check(rd, 32'h00000000);
		apb(1'b1, flash_isp_pkg::IDX_CHIP_CONTROL, ccVal);
		apb(1'b0, flash_isp_pkg::IDX_CHIP_CONTROL, 8'h00);
		check({31'h0, rd[6]}, 32'h00000000);
	endtask : run_op

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task test_reset;
		logic [7:0] idx[6];
		idx = '{8'h9f, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'hae};
		foreach (idx[i]) begin
			apb(1'b0, idx[i], 8'h00);
			check(rd, 32'h00000000);
		end
		apb(1'b0, 8'h10, 8'h00);
		check({31'h0, err}, 32'h00000001);
	endtask : test_reset

	// Trigger while disabled, then enable with the unlock shut and open
	task test_enable;
		apb(1'b1, flash_isp_pkg::IDX_FLASH_TRIGGER, 8'h01);
		repeat (2) @(posedge mclk);
		check({31'h0, hold}, 32'h00000000);
		ta <= 1'b0;
		apb(1'b1, flash_isp_pkg::IDX_CHIP_CONTROL, 8'h01);
		apb(1'b0, flash_isp_pkg::IDX_CHIP_CONTROL, 8'h00);
		check(rd, 32'h00000000);
		ta <= 1'b1;
		apb(1'b1, flash_isp_pkg::IDX_CHIP_CONTROL, 8'h01);
		@(posedge mclk);
		check({31'h0, osc}, 32'h00000001);
		// Enabled now, so only the shut unlock can keep this trigger out
		ta <= 1'b0;
		apb(1'b1, flash_isp_pkg::IDX_FLASH_TRIGGER, 8'h01);
		repeat (2) @(posedge mclk);
		check({31'h0, hold}, 32'h00000000);
		ta <= 1'b1;
	endtask : test_enable

	task test_ops;
		flashRd <= 8'hc3;
		run_op(8'h21, 8'h70, 8'h5a, 4, 1'b0, {2'h2, 18'h07033});
		check({24'h0, seenReq.wdata}, 32'h0000005a);
		run_op(8'h00, 8'h12, 8'h00, 2, 1'b0, {2'h3, 18'h01233});
		apb(1'b0, flash_isp_pkg::IDX_FLASH_DATA, 8'h00);
		check(rd, 32'h000000c3);
		run_op(8'h22, 8'h71, 8'h00, 8, 1'b0, {2'h1, 18'h07100});
		ccVal = 8'h21;
		apb(1'b1, flash_isp_pkg::IDX_CHIP_CONTROL, ccVal);
		run_op(8'h61, 8'h00, 8'h99, 4, 1'b0, {2'h2, 18'h10033});
	endtask : test_ops

	// Each illegal case must fault, move no flash and still release the CPU
	task test_faults;
		logic [7:0] cmds[6];
		cmds = '{8'h22, 8'h61, 8'hc0, 8'h62, 8'h80, 8'h00};
		ccVal = 8'h01;
		foreach (cmds[i]) begin
			inLoader <= (i == 3);
			extFetch <= (i == 5);
			run_op(cmds[i], 8'h01, 8'h00, 0, 1'b1, 20'h00000);
		end
		ccVal = 8'h00;
		apb(1'b1, flash_isp_pkg::IDX_CHIP_CONTROL, 8'h00);
		@(posedge mclk);
		check({31'h0, osc}, 32'h00000000);
	endtask : test_faults

	task end_of_test;
		$display("Checks %0d, mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		{mclk, rstn, psel, penable, pwrite, inLoader, extFetch} = 7'h00;
		ta = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		flashRd = 8'h00;
		ccVal = 8'h01;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		test_reset();
		test_enable();
		test_ops();
		test_faults();
		end_of_test();
	end
endmodule : in_system_flash_programming_bench

`default_nettype wire
